/* hdl/mbx_pkg.sv */
// package: opcodes, widths and timing of the move/branch executor
package mbx_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 10;
  localparam int REG_AW = 6;
  localparam int SFR_AW = 4;
  localparam int STACK_D = 8;
  localparam int SP_W = 3;
  // operation select from the fetch stage
  typedef enum logic [2:0] {
    MBX_NOP = 3'h0,
    MBX_WRITE_SPECIAL_PAGE = 3'h1,
    MBX_SUBROUTINE_CALL = 3'h2,
    MBX_ABSOLUTE_JUMP = 3'h3,
    MBX_LOAD_IMMEDIATE_WORK = 3'h4,
    MBX_STORE_WORK_TO_REG = 3'h5,
    MBX_REGISTER_MOVE = 3'h6,
    MBX_SUBROUTINE_RETURN = 3'h7
  } mbx_op_t;
  localparam int BRANCH_CYCLES = 2;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
endpackage

/* hdl/mbx_stack.sv */
// hardware return-address stack
`timescale 1ns/1ps
module mbx_stack
  import mbx_pkg::*;
#(
  parameter int DEPTH = STACK_D,
  parameter int AW = SP_W
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic push,
  input wire logic pop,
  input wire logic [PC_W-1:0] push_addr,
  output logic [PC_W-1:0] top_addr,
  output logic [AW-1:0] level
);
  logic [PC_W-1:0] mem_r [DEPTH];
  logic [PC_W-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] sp_r;
  logic [AW-1:0] sp_nxt;

  always_comb begin
    mem_nxt = mem_r;
    sp_nxt = sp_r;
    if (push) begin
      mem_nxt[sp_r] = push_addr;
      sp_nxt = sp_r + 1'b1;
    end else if (pop) begin
      sp_nxt = sp_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sp_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= PC_RESET;
      end
    end else begin
      sp_r <= sp_nxt;
      mem_r <= mem_nxt;
    end
  end

  assign top_addr = mem_r[sp_r - 1'b1];
  assign level = sp_r;
endmodule // mbx_stack

/* hdl/mbx_core.sv */
// executor for move, jump, call and return operations
`timescale 1ns/1ps
//
// Contract
// - special-page write copies working register to special register 0..15, one cycle.
// - call pushes next address, loads 10-bit target into pc, two cycles.
// - jump loads 10-bit target into pc, stack untouched, two cycles.
// - load immediate puts 8-bit literal in working register, flags unchanged.
// - store writes working register to data register 0..63, one cycle.
// - register move sends register to work (d=0) or back (d=1).
// - register move updates zero flag, allowing a zero test in place.
// - return reloads pc from stack top and pops it, two cycles.
module mbx_core
  import mbx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  // decoded instruction offered by the fetch stage
  input wire logic instr_valid,
  input wire mbx_op_t instr_op,
  input wire logic [PC_W-1:0] instr_target,
  input wire logic [DATA_W-1:0] instr_literal,
  input wire logic [REG_AW-1:0] instr_reg_addr,
  input wire logic [SFR_AW-1:0] instr_sfr_idx,
  input wire logic instr_dest,
  // handshake and architectural state
  output logic instr_ready,
  output logic [PC_W-1:0] program_counter,
  output logic [DATA_W-1:0] working_register,
  output logic zero_flag,
  // special-page write port, one strobe per write
  output logic [SFR_AW-1:0] sfr_wr_idx,
  output logic [DATA_W-1:0] sfr_wr_data,
  output logic sfr_wr_en,
  // observation only
  output logic [SP_W-1:0] stack_level,
  output logic [DATA_W-1:0] reg_rd_data
);
  localparam int NREG = 1 << REG_AW;

  // run takes one operation per edge; flush drops the word behind a branch
  typedef enum logic {
    MBX_RUN,
    MBX_FLUSH
  } mbx_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // next sequential address; a call pushes the value it would step to
  function automatic logic [PC_W-1:0] step_pc(
    input logic [PC_W-1:0] pc
  );
    return pc + 10'h001;
  endfunction

  // operations that refill the fetch stage and cost a second cycle
  function automatic logic is_branch(input mbx_op_t op);
    return op inside {MBX_SUBROUTINE_CALL, MBX_ABSOLUTE_JUMP,
      MBX_SUBROUTINE_RETURN};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  // sequencing
  mbx_state_t state_r;
  mbx_state_t state_nxt;
  // architectural state
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [DATA_W-1:0] work_r;
  logic [DATA_W-1:0] work_nxt;
  logic zero_r;
  logic zero_nxt;
  // data register file
  logic [DATA_W-1:0] regs_r [NREG];
  logic [DATA_W-1:0] regs_nxt [NREG];
  // special-page write port
  logic [SFR_AW-1:0] sfr_idx_r;
  logic [SFR_AW-1:0] sfr_idx_nxt;
  logic [DATA_W-1:0] sfr_data_r;
  logic [DATA_W-1:0] sfr_data_nxt;
  logic sfr_en_r;
  logic sfr_en_nxt;
  // stack controls
  logic push;
  logic pop;
  logic [PC_W-1:0] top_addr;
  logic [DATA_W-1:0] moved;
  logic take;

  // ready drops for the flush cycle only; nothing else stalls the core
  assign take = instr_valid && (state_r == MBX_RUN);
  assign instr_ready = (state_r == MBX_RUN);
  assign moved = regs_r[instr_reg_addr];

  ////////////////////////////////////////////////////////////////////////////
  // return stack

  // depth is fixed: a ninth nested call wraps the pointer and overwrites
  // the oldest return address, and a return with nothing pushed reads
  // the deepest slot; software must keep nesting within the depth
  mbx_stack #(.DEPTH(STACK_D), .AW(SP_W)) u_stack (
    .core_clk(core_clk),
    .rstn(rstn),
    .push(push),
    .pop(pop),
    .push_addr(step_pc(pc_r)),
    .top_addr(top_addr),
    .level(stack_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // execution

  always_comb begin
    state_nxt = MBX_RUN;
    pc_nxt = pc_r;
    work_nxt = work_r;
    zero_nxt = zero_r;
    regs_nxt = regs_r;
    sfr_idx_nxt = sfr_idx_r;
    sfr_data_nxt = sfr_data_r;
    sfr_en_nxt = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    // defaults hold state; the special-page strobe lasts one cycle
    if (take) begin
      if (!is_branch(instr_op)) begin
        pc_nxt = step_pc(pc_r);
      end
      unique case (instr_op)
        MBX_NOP: begin
          // only the address steps
        end
        MBX_WRITE_SPECIAL_PAGE: begin
          sfr_idx_nxt = instr_sfr_idx;
          sfr_data_nxt = work_r;
          sfr_en_nxt = 1'b1;
        end
        MBX_SUBROUTINE_CALL: begin
          push = 1'b1;
          pc_nxt = instr_target;
          state_nxt = MBX_FLUSH;
        end
        MBX_ABSOLUTE_JUMP: begin
          pc_nxt = instr_target;
          state_nxt = MBX_FLUSH;
        end
        MBX_LOAD_IMMEDIATE_WORK: begin
          work_nxt = instr_literal;
        end
        MBX_STORE_WORK_TO_REG: begin
          regs_nxt[instr_reg_addr] = work_r;
        end
        MBX_REGISTER_MOVE: begin
          // d=1 rewrites the same value, so only the zero flag moves
          if (instr_dest) begin
            regs_nxt[instr_reg_addr] = moved;
          end else begin
            work_nxt = moved;
          end
          zero_nxt = (moved == 8'h00);
        end
        MBX_SUBROUTINE_RETURN: begin
          pop = 1'b1;
          pc_nxt = top_addr;
          state_nxt = MBX_FLUSH;
        end
      endcase
    end else if (state_r == MBX_FLUSH) begin
      // the word fetched behind a branch is dropped here
      state_nxt = MBX_RUN;
    end else begin
      state_nxt = state_r;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= MBX_RUN;
      pc_r <= PC_RESET;
      work_r <= WORK_RESET;
      zero_r <= 1'b0;
      sfr_idx_r <= '0;
      sfr_data_r <= '0;
      sfr_en_r <= 1'b0;
      // cleared so a zero test right after reset is defined
      for (int i = 0; i < NREG; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      work_r <= work_nxt;
      zero_r <= zero_nxt;
      sfr_idx_r <= sfr_idx_nxt;
      sfr_data_r <= sfr_data_nxt;
      sfr_en_r <= sfr_en_nxt;
      regs_r <= regs_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign program_counter = pc_r;
  assign working_register = work_r;
  assign zero_flag = zero_r;
  assign sfr_wr_idx = sfr_idx_r;
  assign sfr_wr_data = sfr_data_r;
  assign sfr_wr_en = sfr_en_r;
  // combinational view of the addressed register, for observation
  assign reg_rd_data = moved;
endmodule // mbx_core

/* sim/mbx_core_checker.sv */
// checker for the move/branch executor ports
`timescale 1ns/1ps
module mbx_core_checker
  import mbx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire mbx_op_t instr_op,
  input wire logic [PC_W-1:0] instr_target,
  input wire logic [DATA_W-1:0] instr_literal,
  input wire logic [SFR_AW-1:0] instr_sfr_idx,
  input wire logic instr_dest,
  input wire logic instr_ready,
  input wire logic [PC_W-1:0] program_counter,
  input wire logic [DATA_W-1:0] working_register,
  input wire logic zero_flag,
  input wire logic [SFR_AW-1:0] sfr_wr_idx,
  input wire logic [DATA_W-1:0] sfr_wr_data,
  input wire logic sfr_wr_en,
  input wire logic [SP_W-1:0] stack_level,
  input wire logic [DATA_W-1:0] reg_rd_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  mbx_op_t c;
  // operation actually taken this edge
  assign c = instr_valid && instr_ready ? instr_op : MBX_NOP;
  ////////////////////////////////////////////////////////////////
  property p_sfr; c == MBX_WRITE_SPECIAL_PAGE |=> sfr_wr_en &&
    sfr_wr_idx == $past(instr_sfr_idx) &&
    sfr_wr_data == $past(working_register); endproperty
  a_sfr: assert property (p_sfr) else $error("sfr write");
  property p_pls;
    sfr_wr_en |-> $past(c) == MBX_WRITE_SPECIAL_PAGE; endproperty
  a_pls: assert property (p_pls) else $error("sfr pulse");
  property p_call; c == MBX_SUBROUTINE_CALL |=> !instr_ready &&
    program_counter == $past(instr_target) &&
    stack_level == $past(stack_level) + 3'h1 ##1 instr_ready; endproperty
  a_call: assert property (p_call) else $error("call");
  property p_jmp; c == MBX_ABSOLUTE_JUMP |=> !instr_ready &&
    program_counter == $past(instr_target) &&
    $stable(stack_level) ##1 instr_ready; endproperty
  a_jmp: assert property (p_jmp) else $error("jump");
  property p_ret; c == MBX_SUBROUTINE_RETURN |=> !instr_ready &&
    stack_level == $past(stack_level) - 3'h1 ##1 instr_ready; endproperty
  a_ret: assert property (p_ret) else $error("return");
  property p_ldi; c == MBX_LOAD_IMMEDIATE_WORK |=>
    working_register == $past(instr_literal) && $stable(zero_flag);
  endproperty
  a_ldi: assert property (p_ldi) else $error("load");
  property p_sto; c == MBX_STORE_WORK_TO_REG |=>
    $stable(working_register) && $stable(zero_flag); endproperty
  a_sto: assert property (p_sto) else $error("store");
  property p_mov; c == MBX_REGISTER_MOVE |=>
    zero_flag == ($past(reg_rd_data) == 8'h00) && working_register ==
    ($past(instr_dest) ? $past(working_register) : $past(reg_rd_data));
  endproperty
  a_mov: assert property (p_mov) else $error("move");
  c_call: cover property (c == MBX_SUBROUTINE_CALL);
  c_ret: cover property (c == MBX_SUBROUTINE_RETURN);
  c_zero: cover property (c == MBX_REGISTER_MOVE ##1 zero_flag);
endmodule // mbx_core_checker
bind mbx_core mbx_core_checker u_chk (.*);

/* sim/mbx_core_tb.sv */
// self-checking bench for the move/branch executor
`timescale 1ns/1ps
module mbx_core_tb import mbx_pkg::*;;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic instr_valid = 1'b0;
  mbx_op_t instr_op = MBX_NOP;
  logic [PC_W-1:0] instr_target = '0;
  logic [DATA_W-1:0] instr_literal = '0;
  logic [REG_AW-1:0] instr_reg_addr = '0;
  logic [SFR_AW-1:0] instr_sfr_idx = '0;
  logic instr_dest = 1'b0;
  logic instr_ready, zero_flag, sfr_wr_en, z, pend, ck, se;
  logic [PC_W-1:0] program_counter, pc, rs;
  logic [DATA_W-1:0] working_register, sfr_wr_data, reg_rd_data, wk, rg [64];
  logic [DATA_W-1:0] sd;
  logic [SFR_AW-1:0] sfr_wr_idx, si;
  logic [SP_W-1:0] stack_level, lv;
  logic [34:0] q [$], e;
  int fail_count, comparisons;
  always #2.5 core_clk = ~core_clk;
  mbx_core DUT (.*);
  ////////////////////////////////////////////////////////////////
  task stop_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task iss(mbx_op_t o, logic [9:0] t, logic [7:0] l, logic [5:0] a, logic d);
    @(posedge core_clk);
    instr_op <= o;
    {instr_target, instr_literal, instr_reg_addr} <= {t, l, a};
    {instr_sfr_idx, instr_dest, instr_valid} <= {a[3:0], d, 1'b1};
    ck = o inside {MBX_SUBROUTINE_CALL, MBX_ABSOLUTE_JUMP,
      MBX_SUBROUTINE_RETURN};
    case (o)
      MBX_LOAD_IMMEDIATE_WORK: wk = l;
      MBX_WRITE_SPECIAL_PAGE: {si, sd} = {a[3:0], wk};
      MBX_STORE_WORK_TO_REG: rg[a] = wk;
      MBX_REGISTER_MOVE: {z, wk} = {rg[a] == 8'h00, d ? wk : rg[a]};
      MBX_SUBROUTINE_CALL: {rs, pc, lv} = {pc + 10'h1, t, lv + 3'h1};
      MBX_ABSOLUTE_JUMP: pc = t;
      MBX_SUBROUTINE_RETURN: {pc, lv} = {rs, lv - 3'h1};
      default: ;
    endcase
    se = o == MBX_WRITE_SPECIAL_PAGE;
    if (!ck) pc = pc + 10'h1;
    q.push_back({pc, wk, z, lv, se, si, sd});
    if (ck) begin
      @(posedge core_clk);
      instr_valid <= 1'b0;
    end
  endtask
  always @(negedge core_clk) begin
    if (pend) begin
      e = q.pop_front();
      comparisons++;
      if ({program_counter, working_register, zero_flag, stack_level,
          sfr_wr_en, sfr_wr_idx,
          sfr_wr_data} !== e) begin
        fail_count++;
        $display("[FAIL] state exp %h got %h", e,
          {program_counter, working_register, zero_flag, stack_level,
          sfr_wr_en, sfr_wr_idx, sfr_wr_data});
      end
    end
    pend = instr_valid && instr_ready;
  end
  initial begin
    #2000;
    fail_count++;
    stop_test;
  end
  initial begin
    void'($urandom(32'h4d47));
    {pc, wk, z, lv, pend} = {PC_RESET, WORK_RESET, 1'b0, 3'h0, 1'b0};
    {se, si, sd} = 13'h0000;
    foreach (rg[i]) rg[i] = REG_RESET;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      iss(MBX_LOAD_IMMEDIATE_WORK, 0, i ? 8'($urandom) : 8'h00, 0, 0);
      iss(MBX_STORE_WORK_TO_REG, 0, 0, 6'(i * 9), 0);
      iss(MBX_WRITE_SPECIAL_PAGE, 0, 0, 6'(i * 9), 0);
    end
    $display("test store and sfr done");
    iss(MBX_SUBROUTINE_CALL, 10'($urandom), 0, 0, 0);
    iss(MBX_LOAD_IMMEDIATE_WORK, 0, 8'h5a, 0, 0);
    iss(MBX_NOP, 0, 0, 0, 0);
    iss(MBX_SUBROUTINE_RETURN, 0, 0, 0, 0);
    iss(MBX_ABSOLUTE_JUMP, 10'h3ff, 0, 0, 0);
    for (int i = 0; i < 8; i++) begin
      iss(MBX_REGISTER_MOVE, 0, 0, 6'(i * 9), 1'($urandom));
    end
    @(posedge core_clk);
    instr_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    $display("test branch and move done");
    stop_test;
  end
endmodule // mbx_core_tb
